// File: rtl/bus_matrix_defs.vh
`ifndef BUS_MATRIX_DEFS_VH
`define BUS_MATRIX_DEFS_VH
// Master port numbers.
`define M_CORE_IDATA      2'h0
`define M_CORE_SYS        2'h1
`define M_PERIPH_DMA      2'h2
`define M_CRC_CALC        2'h3
// Slave port numbers.
`define S_SRAM            3'h0
`define S_ROM             3'h1
`define S_FLASH           3'h2
`define S_EXT_BUS         3'h3
`define S_BRIDGE          3'h4
`define S_NONE            3'h7
// Allowed path table: bit m*5+s set when master m may reach slave s.
`define PATH_ALLOW        20'h7_EF26
// Address map bases and region sizes (address bits above the size select).
`define SRAM_BASE         32'h2000_0000
`define SRAM_MASK         32'hFFF0_0000
`define BB_ALIAS_BASE     32'h2200_0000
`define BB_ALIAS_MASK     32'hFE00_0000
`define ROM_BASE          32'h0080_0000
`define ROM_MASK          32'hFFF0_0000
`define FLASH_BASE        32'h0040_0000
`define FLASH_MASK        32'hFFC0_0000
`define EXT_BASE          32'h6000_0000
`define EXT_MASK          32'hF000_0000
`define BRIDGE_BASE       32'h4000_0000
`define BRIDGE_MASK       32'hF000_0000
// DMA arbitration overhead in main clock cycles.
`define DMA_OVH_M2P       2'h1
`define DMA_OVH_P2M       2'h2
// DMA channel count (12 transmit, 11 receive).
`define DMA_CHANNELS      23
`endif

// File: rtl/system_bus_matrix.v
`timescale 1ns/10ps
// Summary of operation
// - Four masters run concurrently to distinct slaves.
// - Every master decodes with identical address map.
// - Five slaves, each with own arbiter.
// - Masters: core I/D, core system, DMA, CRC.
// - Slaves: SRAM, ROM, flash, external, bridge.
// - Forbidden master-to-slave paths are not wired.
// - SRAM decoded at base 0x2000_0000.
// - Bit-band alias window 0x2200_0000 to 0x23FF_FFFF.
// - ROM always at 0x0080_0000, never remapped.
// - Bridge peripherals run on main system clock.
// - DMA overhead: one cycle out, two in.
// - DMA fixed priority, receive above transmit.
`include "bus_matrix_defs.vh"
module system_bus_matrix (
    input  wire         REF_CLK,     // Main system clock, also the bridge clock.
    input  wire         RST,         // Synchronous active-high reset.
    input  wire [3:0]   M_REQ,       // Per-master request, held until M_READY.
    input  wire [3:0]   M_WRITE,     // Per-master write flag.
    input  wire [127:0] M_ADDR,      // Master m address at bits 32m+31:32m.
    input  wire [127:0] M_WDATA,     // Master m write data.
    output wire [3:0]   M_READY,     // Combinational: access taken this cycle.
    output reg  [3:0]   M_DONE,      // One-cycle pulse when data returned.
    output reg  [3:0]   M_ERR,       // Pulse with M_DONE on unmapped or forbidden path.
    output reg  [127:0] M_RDATA,     // Read data, valid with M_DONE.
    output reg  [4:0]   S_SEL,       // Per-slave access strobe, one cycle.
    output reg  [4:0]   S_WRITE,     // Per-slave write flag.
    output reg  [159:0] S_ADDR,      // Slave s address at bits 32s+31:32s.
    output reg  [159:0] S_WDATA,     // Slave s write data.
    output reg  [4:0]   S_BITOP,     // Access is a bit-band single-bit operation.
    output reg  [24:0]  S_BITSEL,    // Slave s bit index at 5s+4:5s.
    output reg  [7:0]   S_MASTER,    // Granted master number, 2 bits per slave for slaves 0 to 3; slave 4 has no field.
    input  wire [159:0] S_RDATA,     // Slave read data, valid with S_ACK.
    input  wire [4:0]   S_ACK,       // Slave completion pulse.
    input  wire [22:0]  DMA_CH_REQ,  // DMA channel requests, bit 0 lowest priority.
    input  wire         DMA_P2M,     // Current DMA transfer is peripheral to memory.
    output reg  [4:0]   DMA_CH_GNT,  // Channel number chosen for service.
    output reg          DMA_CH_VLD,  // A channel is chosen.
    output reg          DMA_OVH_BUSY // DMA is spending arbitration overhead.
);
    // Decoded target per master and whether it is a bit-band alias access.
    reg  [2:0]  tgt    [0:3];
    reg  [3:0]  is_bb;
    reg  [3:0]  allowed;             // Path exists and address is mapped.
    // Per-slave owner state and per-master pending flags.
    reg  [4:0]  busy_q;              // Slave holds a transaction in flight.
    reg  [1:0]  own_q  [0:4];        // Master owning each slave.
    reg  [1:0]  last_q [0:4];        // Last granted master, for rotation.
    reg  [3:0]  grant  [0:4];        // One-hot grant per slave this cycle.
    reg  [3:0]  pend_q;              // Master waits for completion.
    // DMA overhead counter.
    reg  [1:0]  ovh_q;
    reg  [1:0]  ovh_d;
    integer m;                       // Master index of the sequential block.
    integer s;                       // Slave index of the sequential block.
    integer dm;                      // Master index of the decoders.
    integer am;                      // Candidate master of the arbiters.
    integer ak;                      // Rotation step of the arbiters.
    integer asl;                     // Slave index of the arbiters.
    integer dk;                      // Channel index of the DMA priority pick.
    // Path table held as a vector, since a bare literal cannot be bit-selected.
    localparam [19:0] path_allow = `PATH_ALLOW;

    // Each master owns a decoder; all share one map, so any master sees the same slave.
    // Every process keeps its own loop index, so no process retriggers another
    // through a shared variable.
    always @* begin
        for (dm = 0; dm < 4; dm = dm + 1) begin
            is_bb[dm] = 1'b0;
            tgt[dm]   = `S_NONE;
            if ((M_ADDR[32*dm +: 32] & `SRAM_MASK) == `SRAM_BASE) begin
                tgt[dm] = `S_SRAM;
            end else if ((M_ADDR[32*dm +: 32] & `BB_ALIAS_MASK) == `BB_ALIAS_BASE) begin
                tgt[dm]   = `S_SRAM;
                is_bb[dm] = 1'b1;
            end else if ((M_ADDR[32*dm +: 32] & `ROM_MASK) == `ROM_BASE) begin
                tgt[dm] = `S_ROM;
            end else if ((M_ADDR[32*dm +: 32] & `FLASH_MASK) == `FLASH_BASE) begin
                tgt[dm] = `S_FLASH;
            end else if ((M_ADDR[32*dm +: 32] & `EXT_MASK) == `EXT_BASE) begin
                tgt[dm] = `S_EXT_BUS;
            end else if ((M_ADDR[32*dm +: 32] & `BRIDGE_MASK) == `BRIDGE_BASE) begin
                tgt[dm] = `S_BRIDGE;
            end
            // Unwired paths are refused here, never routed; unmapped never indexes the table.
            allowed[dm] = (tgt[dm] == `S_NONE) ? 1'b0 :
                          path_allow[dm*5 + tgt[dm]];
        end
    end

    // Per-slave round-robin arbiters; a busy slave grants nobody, so losers stall.
    // The candidate after the last winner is tried last in the loop, so it wins.
    always @* begin
        am = 0;
        for (asl = 0; asl < 5; asl = asl + 1) begin
            grant[asl] = 4'h0;
            if (!busy_q[asl]) begin
                for (ak = 4; ak >= 1; ak = ak - 1) begin
                    am = (last_q[asl] + ak) % 4;
                    if (M_REQ[am] && !pend_q[am] && allowed[am] &&
                        tgt[am] == asl[2:0]) begin
                        grant[asl] = 4'h1 << am;
                    end
                end
            end
        end
    end

    // A master is taken when some slave grants it, or at once if refused.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_rdy
            assign M_READY[g] = M_REQ[g] && !pend_q[g] &&
                (!allowed[g] || grant[0][g] || grant[1][g] || grant[2][g] ||
                 grant[3][g] || grant[4][g]);
        end
    endgenerate

    // Issue strobes, track ownership and return completions to owners.
    always @(posedge REF_CLK) begin
        if (RST) begin
            busy_q   <= 5'h0_0;
            pend_q   <= 4'h0;
            S_SEL    <= 5'h0_0;
            S_WRITE  <= 5'h0_0;
            S_BITOP  <= 5'h0_0;
            S_ADDR   <= 160'h0;
            S_WDATA  <= 160'h0;
            S_BITSEL <= 25'h0;
            S_MASTER <= 8'h00;
            M_DONE   <= 4'h0;
            M_ERR    <= 4'h0;
            M_RDATA  <= 128'h0;
            for (s = 0; s < 5; s = s + 1) begin
                own_q[s]  <= 2'h0;
                last_q[s] <= 2'h3;
            end
        end else begin
            S_SEL  <= 5'h0_0;
            M_DONE <= 4'h0;
            M_ERR  <= 4'h0;
            // Refused accesses complete next cycle with an error.
            for (m = 0; m < 4; m = m + 1) begin
                if (M_REQ[m] && !pend_q[m] && !allowed[m]) begin
                    M_DONE[m] <= 1'b1;
                    M_ERR[m]  <= 1'b1;
                end
            end
            for (s = 0; s < 5; s = s + 1) begin
                // Completion is checked first so a slave may be re-granted later.
                if (busy_q[s] && S_ACK[s]) begin
                    busy_q[s]                  <= 1'b0;
                    pend_q[own_q[s]]           <= 1'b0;
                    M_DONE[own_q[s]]           <= 1'b1;
                    M_RDATA[32*own_q[s] +: 32] <= S_RDATA[32*s +: 32];
                end
                for (m = 0; m < 4; m = m + 1) begin
                    if (grant[s][m]) begin
                        busy_q[s]         <= 1'b1;
                        pend_q[m]         <= 1'b1;
                        own_q[s]          <= m[1:0];
                        last_q[s]         <= m[1:0];
                        S_MASTER[2*s +: 2] <= m[1:0];
                        S_SEL[s]          <= 1'b1;
                        S_WRITE[s]        <= M_WRITE[m];
                        S_WDATA[32*s +: 32] <= M_WDATA[32*m +: 32];
                        S_BITOP[s]        <= is_bb[m];
                        if (is_bb[m]) begin
                            // Alias word n maps to SRAM word n/32, bit n%32.
                            // The slave gets a plain word address and does the RMW itself.
                            S_ADDR[32*s +: 32] <= `SRAM_BASE |
                                {12'h000, M_ADDR[32*m+7 +: 18], 2'b00};
                            S_BITSEL[5*s +: 5] <= M_ADDR[32*m+2 +: 5];
                        end else begin
                            S_ADDR[32*s +: 32] <= M_ADDR[32*m +: 32];
                            S_BITSEL[5*s +: 5] <= 5'h00;
                        end
                    end
                end
            end
        end
    end

    // Fixed-priority DMA channel pick: highest index wins, receive sits above transmit.
    always @(posedge REF_CLK) begin
        if (RST) begin
            DMA_CH_GNT <= 5'h00;
            DMA_CH_VLD <= 1'b0;
        end else begin
            DMA_CH_VLD <= |DMA_CH_REQ;
            DMA_CH_GNT <= 5'h00;
            // Later channels overwrite earlier ones, so the highest pending index is kept.
            for (dk = 0; dk < `DMA_CHANNELS; dk = dk + 1) begin
                if (DMA_CH_REQ[dk]) begin
                    DMA_CH_GNT <= dk[4:0];
                end
            end
        end
    end

    // Overhead counter loaded when the DMA master is granted a slave.
    // Refused DMA accesses never reach a slave, so they cost no overhead.
    always @* begin
        ovh_d = (ovh_q != 2'h0) ? ovh_q - 2'h1 : 2'h0;
        if (M_READY[`M_PERIPH_DMA] && allowed[`M_PERIPH_DMA]) begin
            ovh_d = DMA_P2M ? `DMA_OVH_P2M : `DMA_OVH_M2P;
        end
    end

    // Busy flag follows the counter; it is a status level, not a stall.
    always @(posedge REF_CLK) begin
        if (RST) begin
            ovh_q        <= 2'h0;
            DMA_OVH_BUSY <= 1'b0;
        end else begin
            ovh_q        <= ovh_d;
            DMA_OVH_BUSY <= (ovh_d != 2'h0);
        end
    end
endmodule

// File: verif/system_bus_matrix_chk.sv
`timescale 1ns/10ps
module system_bus_matrix_chk (
    input wire         REF_CLK,
    input wire         RST,
    input wire [3:0]   M_REQ,
    input wire [127:0] M_ADDR,
    input wire [3:0]   M_WRITE,
    input wire [127:0] M_WDATA,
    input wire [3:0]   M_READY,
    input wire [3:0]   M_DONE,
    input wire [3:0]   M_ERR,
    input wire [4:0]   S_SEL,
    input wire [4:0]   S_WRITE,
    input wire [159:0] S_WDATA,
    input wire [159:0] S_ADDR,
    input wire [4:0]   S_BITOP,
    input wire [24:0]  S_BITSEL,
    input wire [7:0]   S_MASTER,
    input wire [22:0]  DMA_CH_REQ,
    input wire         DMA_P2M,
    input wire [4:0]   DMA_CH_GNT,
    input wire         DMA_CH_VLD,
    input wire         DMA_OVH_BUSY
);
    // One clock domain, so one default clock and reset serve every check.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire [3:0] tk = M_REQ & M_READY;  // Requests taken at this edge.
    property p_sram;
        tk[1] && M_ADDR[63:52] == 12'h200 |=> S_SEL[0] && S_MASTER[1:0] == 2'h1
            && S_ADDR[31:0] == $past(M_ADDR[63:32]) && S_WRITE[0] == $past(M_WRITE[1])
            && S_WDATA[31:0] == $past(M_WDATA[63:32]);
    endproperty
    a_sram: assert property (p_sram) else $error("sram access not routed");
    property p_rom;
        tk[0] && M_ADDR[31:20] == 12'h008 |=> S_SEL[1] && S_MASTER[3:2] == 2'h0;
    endproperty
    a_rom: assert property (p_rom) else $error("rom access not routed");
    property p_forbid;
        tk[0] && M_ADDR[31:20] == 12'h200 |=> M_DONE[0] && M_ERR[0]
            && !(S_SEL[0] && S_MASTER[1:0] == 2'h0);
    endproperty
    a_forbid: assert property (p_forbid) else $error("missing path answered");
    property p_onegnt;
        M_REQ[1] && M_REQ[2] && M_ADDR[63:52] == 12'h200 && M_ADDR[95:84] == 12'h200
            |-> !(M_READY[1] && M_READY[2]);
    endproperty
    a_onegnt: assert property (p_onegnt) else $error("two masters granted");
    property p_bitband;
        tk[1] && M_ADDR[63:57] == 7'h11 |=> S_SEL[0] && S_BITOP[0]
            && S_BITSEL[4:0] == $past(M_ADDR[38:34])
            && S_ADDR[31:0] == {12'h200, $past(M_ADDR[56:39]), 2'b00};
    endproperty
    a_bitband: assert property (p_bitband) else $error("alias conversion wrong");
    property p_dma_top;
        DMA_CH_REQ[22] |=> DMA_CH_VLD && DMA_CH_GNT == 5'h16;
    endproperty
    a_dma_top: assert property (p_dma_top) else $error("top channel not chosen");
    property p_ovh1;
        tk[2] && !DMA_P2M ##1 !M_ERR[2] |-> DMA_OVH_BUSY ##1 !DMA_OVH_BUSY;
    endproperty
    a_ovh1: assert property (p_ovh1) else $error("outbound overhead wrong");
    property p_ovh2;
        tk[2] && DMA_P2M ##1 !M_ERR[2] |-> DMA_OVH_BUSY [*2] ##1 !DMA_OVH_BUSY;
    endproperty
    a_ovh2: assert property (p_ovh2) else $error("inbound overhead wrong");
    c_all: cover property (M_READY == 4'hF);
    c_bb: cover property (S_BITOP[0]);
    c_three: cover property (M_REQ[3:1] == 3'h7 && S_SEL[0]);
endmodule
bind system_bus_matrix system_bus_matrix_chk CHK (.*);

// File: verif/slave_responder.sv
`timescale 1ns/10ps
// Five slaves; each answers its strobe with one acknowledge pulse.
module slave_responder (
    input  wire          clk,
    input  wire          rst,
    input  wire [4:0]    sel,
    input  wire [159:0]  addr,
    input  wire          slow,   // Answer after six cycles instead of one.
    output logic [4:0]   ack,
    output logic [159:0] rdata
);
    for (genvar s = 0; s < 5; s++) begin : g_slv
        logic [2:0]  cnt_q;  // Cycles left before the answer.
        logic [31:0] val_q;  // Word to return, derived from the address.
        // Off the answer cycle the bus shows the inverse, so stale data cannot pass.
        always @(posedge clk) begin
            ack[s] <= 1'b0;
            rdata[32*s+:32] <= ~val_q;
            if (rst) begin
                cnt_q <= 3'h0;
                val_q <= 32'h0000_0000;
            end else if (sel[s]) begin
                cnt_q <= slow ? 3'h6 : 3'h1;
                val_q <= addr[32*s+:32] ^ 32'hA5A5_0000;
            end else if (cnt_q == 3'h1) begin
                ack[s] <= 1'b1;
                rdata[32*s+:32] <= val_q;
                cnt_q <= 3'h0;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule

// File: verif/system_bus_matrix_tb.sv
`timescale 1ns/10ps
module system_bus_matrix_tb;
    logic REF_CLK = 1'b0, RST = 1'b1, slow = 1'b0, DMA_P2M = 1'b0;
    logic [3:0] M_REQ = 4'h0, M_WRITE = 4'h0, M_READY, M_DONE, M_ERR;
    logic [127:0] M_ADDR = '0, M_WDATA = '0, M_RDATA;
    logic [4:0] S_SEL, S_WRITE, S_BITOP, S_ACK, DMA_CH_GNT;
    logic [159:0] S_ADDR, S_WDATA, S_RDATA;
    logic [24:0] S_BITSEL;
    logic [7:0] S_MASTER;
    logic [22:0] DMA_CH_REQ = '0;
    logic DMA_CH_VLD, DMA_OVH_BUSY;
    int n_errors = 0, checks_done = 0, busy_n;
    localparam logic [19:0] ALLOW = 20'h7_EF26;  // Bit m*5+s: master m reaches slave s.
    localparam logic [31:0] BASE [5] = '{32'h2000_0010, 32'h0080_0010, 32'h0040_0010,
                                         32'h6000_0010, 32'h4000_0010};
    always #12.5 REF_CLK = ~REF_CLK;
    // Counts overhead cycles; the DMA test clears it before each of its two measured transfers.
    always @(posedge REF_CLK) if (DMA_OVH_BUSY === 1'b1) busy_n <= busy_n + 1;
    system_bus_matrix DUT (.*);
    slave_responder SLV (.clk(REF_CLK), .rst(RST), .sel(S_SEL), .addr(S_ADDR),
                         .slow(slow), .ack(S_ACK), .rdata(S_RDATA));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One access by master m, entered just after an edge; sa is the slave's address.
    task automatic access(input int m, input logic [31:0] a, sa, input logic w, err);
        int n = 0;
        M_REQ[m] <= 1'b1;
        M_WRITE[m] <= w;
        M_ADDR[32*m+:32] <= a;
        M_WDATA[32*m+:32] <= ~a;
        do @(posedge REF_CLK); while (M_READY[m] !== 1'b1 && ++n < 300);
        M_REQ[m] <= 1'b0;
        do @(posedge REF_CLK); while (M_DONE[m] !== 1'b1 && ++n < 300);
        if (n >= 300) n_errors++;
        chk("error flag", {31'h0, err}, {31'h0, M_ERR[m]});
        if (!err && !w) chk("read data", sa ^ 32'hA5A5_0000, M_RDATA[32*m+:32]);
    endtask
    task automatic t_paths();
        for (int i = 0; i < 20; i++) begin
            @(posedge REF_CLK);
            access(i / 5, BASE[i%5], BASE[i%5], i[0], !ALLOW[i]);
        end
        access(3, 32'h1000_0000, 0, 1'b0, 1'b1);
        $display("paths test done");
    endtask
    // Distinct slaves run together; a shared slave admits one master at a time.
    task automatic t_share(input logic sl, input logic [31:0] a0, a2, a3, input int nr);
        slow <= sl;
        @(posedge REF_CLK);
        fork
            if (!sl) access(0, a0, a0, 1'b0, 1'b0);
            access(1, 32'h2000_0040, 32'h2000_0040, 1'b0, 1'b0);
            access(2, a2, a2, 1'b0, 1'b0);
            access(3, a3, a3, 1'b0, 1'b0);
            #1 chk("ready count", nr, $countones(M_READY));
        join
        $display("sharing test done");
    endtask
    task automatic t_bitband();
        access(1, 32'h2200_01FC, 32'h2000_000C, 1'b0, 1'b0);
        access(1, 32'h23FF_FFFC, 32'h200F_FFFC, 1'b0, 1'b0);
        access(1, 32'h2400_0000, 0, 1'b0, 1'b1);
        access(2, 32'h2200_0080, 32'h2000_0004, 1'b1, 1'b0);
        $display("bit-band test done");
    endtask
    task automatic t_dma();
        for (int c = 0; c < 24; c++) begin
            DMA_CH_REQ <= (c == 23) ? 23'h00_1801 : 23'h7F_FFFF >> (22 - c);
            repeat (2) @(posedge REF_CLK);
            chk("dma grant", (c == 23) ? 32'h2C : 32'h20 | c, {DMA_CH_VLD, DMA_CH_GNT});
        end
        DMA_CH_REQ <= '0;
        for (int p = 0; p < 2; p++) begin
            busy_n = 0;
            DMA_P2M <= p[0];
            access(2, 32'h2000_0030, 32'h2000_0030, 1'b0, 1'b0);
            chk("overhead cycles", p + 1, busy_n);
        end
        $display("dma test done");
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        chk("idle after reset", 0, {M_DONE, S_SEL, DMA_CH_VLD, DMA_OVH_BUSY});
        t_paths();
        t_share(1'b0, 32'h0080_0020, 32'h6000_0020, 32'h0040_0020, 4);
        t_share(1'b1, 0, 32'h2000_0044, 32'h2000_0048, 1);
        t_bitband();
        t_dma();
        stop_test();
    end
    // The run needs well under a thousand cycles; eight thousand means a hang.
    initial begin
        #(25 * 8000);
        n_errors++;
        stop_test();
    end
endmodule
